// ### rafw_top.sv
// Core of the access freeze watchdog: time counter, missed-tick watchdog
// and compensation. Assumes tick_1hz is asynchronous to clk and the link
// framing arrives on link_clk.
`timescale 1ns/1ps
`default_nettype none
module rafw_top
	import rafw_pkg::*;
(
	// Core clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Timebase
	input wire logic tick_1hz,
	// Serial link framing
	input wire logic link_clk,
	input wire logic start_det,
	input wire logic stop_det,
	input wire logic wr_stb,
	input wire logic [TIME_W-1:0] wr_data,
	// Status
	output logic [TIME_W-1:0] time_count,
	output logic counter_hold,
	output logic [WD_W-1:0] wd_count,
	output logic forced_stop
);
	rafw_xing_if xing ();

	rafw_link u_link (
		.link_clk(link_clk),
		.nrst(nrst),
		.start_det(start_det),
		.stop_det(stop_det),
		.wr_stb(wr_stb),
		.wr_data(wr_data),
		.xing(xing)
	);

	logic tick_meta, tick_s, tick_d;
	logic hold_meta, hold_s;
	logic ld_meta, ld_s, ld_d;
	logic tick_rise, ld_evt;

	// Every asynchronous input except load_data passes two flops before anything reads it.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tick_meta <= 1'b0;
			tick_s <= 1'b0;
			tick_d <= 1'b0;
			hold_meta <= 1'b0;
			hold_s <= 1'b0;
			ld_meta <= 1'b0;
			ld_s <= 1'b0;
			ld_d <= 1'b0;
		end else begin
			tick_meta <= tick_1hz; // R18
			tick_s <= tick_meta;
			tick_d <= tick_s;
			hold_meta <= xing.hold; // R18
			hold_s <= hold_meta;
			ld_meta <= xing.load_tgl;
			ld_s <= ld_meta;
			ld_d <= ld_s;
		end
	end

	assign tick_rise = tick_s && !tick_d;
	assign ld_evt = ld_s != ld_d;

	rafw_state_t state_reg, state_next;
	logic [TIME_W-1:0] time_reg, time_next;
	logic [WD_W-1:0] wd_reg, wd_next;
	logic abort_reg, abort_next;
	logic forced_reg, forced_next;

	// The written value is stable for at least one core cycle before its toggle
	// is seen, so it is safe to read it without its own synchroniser.
	always_comb begin
		state_next = state_reg;
		time_next = time_reg;
		wd_next = wd_reg;
		abort_next = abort_reg;
		forced_next = 1'b0;
		unique case (state_reg)
			RAFW_IDLE: begin
				wd_next = WD_CLR;
				if (hold_s) begin
					state_next = RAFW_HELD; // R02 R03
					if (tick_rise) begin
						wd_next = WD_ONE; // R05 R06
					end
				end else if (tick_rise) begin
					time_next = time_reg + TIME_ONE; // R01
				end
				// The hold and the load toggle cross separately and may be
				// seen a cycle apart; a late toggle is still loaded here.
				if (ld_evt) begin
					time_next = xing.load_data +
						(tick_rise ? TIME_ONE : TIME_RST); // R12
				end
			end
			RAFW_HELD: begin
				if (hold_s && tick_rise) begin
					if (wd_reg == WD_ONE) begin
						// Second missed edge: one pulse only, one second lost.
						wd_next = WD_CLR; // R08 R09 R10
						time_next = time_reg + TIME_ONE; // R10
						abort_next = 1'b1; // R09
						forced_next = 1'b1;
						state_next = RAFW_ABORTED;
					end else begin
						wd_next = wd_reg + WD_ONE; // R04 R06
					end
				end else if (!hold_s) begin
					if (ld_evt) begin
						time_next = xing.load_data; // R12
					end
					if (wd_reg != WD_CLR || tick_rise) begin
						time_next = (ld_evt ? xing.load_data : time_reg) +
							TIME_ONE; // R07
					end
					wd_next = WD_CLR; // R07
					state_next = RAFW_IDLE;
				end
			end
			RAFW_ABORTED: begin
				wd_next = WD_CLR;
				if (tick_rise) begin
					time_next = time_reg + TIME_ONE; // R01
				end
				if (!hold_s) begin
					abort_next = 1'b0;
					state_next = RAFW_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= RAFW_IDLE;
			time_reg <= TIME_RST;
			wd_reg <= WD_CLR;
			abort_reg <= 1'b0;
			forced_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			time_reg <= time_next;
			wd_reg <= wd_next;
			abort_reg <= abort_next;
			forced_reg <= forced_next;
		end
	end

	assign xing.abort = abort_reg;
	assign time_count = time_reg;
	assign counter_hold = state_reg == RAFW_HELD;
	assign wd_count = wd_reg;
	assign forced_stop = forced_reg;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	a_run_idle: assert property (state_reg == RAFW_IDLE && !hold_s &&
		tick_rise |=> time_reg == $past(time_reg) + TIME_ONE) // R01
		else $error("time did not advance while idle");
	a_freeze_held: assert property (state_reg == RAFW_HELD && hold_s &&
		!(tick_rise && wd_reg == WD_ONE) |=> $stable(time_reg)) // R02 R05
		else $error("time moved while held");
	a_hold_enter: assert property (state_reg == RAFW_IDLE && hold_s
		|=> counter_hold) // R03
		else $error("hold not entered");
	a_wd_counts: assert property (state_reg == RAFW_HELD && hold_s &&
		tick_rise && wd_reg == WD_CLR |=> wd_reg == WD_ONE) // R04 R06
		else $error("watchdog missed a held tick");
	a_wd_cleared: assert property (state_reg != RAFW_HELD
		|-> wd_reg == WD_CLR) // R07
		else $error("watchdog not cleared outside hold");
	a_wd_sat: assert property (wd_reg <= WD_MAX) // R08
		else $error("watchdog beyond maximum");
	a_abort_once: assert property (state_reg == RAFW_HELD && hold_s &&
		tick_rise && wd_reg == WD_ONE |=> state_reg == RAFW_ABORTED &&
		forced_stop && time_reg == $past(time_reg) + TIME_ONE) // R09 R10
		else $error("forced stop not one pulse");
	a_release_comp: assert property (state_reg == RAFW_HELD && !hold_s &&
		wd_reg == WD_ONE && !tick_rise && !ld_evt
		|=> time_reg == $past(time_reg) + TIME_ONE ##1
		time_reg == $past(time_reg)) // R07
		else $error("missed tick not compensated");
	a_load_write: assert property (state_reg == RAFW_HELD && !hold_s &&
		ld_evt && wd_reg == WD_CLR && !tick_rise
		|=> time_reg == $past(xing.load_data)) // R12
		else $error("written time not loaded");
	a_abort_req: assert property (state_reg == RAFW_ABORTED
		|-> xing.abort && !counter_hold) // R09
		else $error("abort not requested");

	c_read_ok: cover property (state_reg == RAFW_HELD && !hold_s &&
		wd_reg == WD_ONE);
	c_forced: cover property (forced_stop);
	c_write: cover property (ld_evt && state_reg == RAFW_HELD);
endmodule
`default_nettype wire

// ### rafw_pkg.sv
// Shared constants and types for the access freeze watchdog block.
// Assumes one core clock (clk) and one serial link clock (link_clk).
//
// What this block and its host must do
// [R01] Without a bus access the time counter advances on every 1 Hz tick.
// [R02] Any register read or write over the bus freezes the time counter.
// [R03] Access start raises counter_hold; the counter does not count meanwhile.
// [R04] While counter_hold is high the watchdog is released from clear.
// [R05] A 1 Hz rising edge during counter_hold does not increment time.
// [R06] Each held 1 Hz rising edge increments the watchdog.
// [R07] On hold release, one extra pulse if a tick was missed, then clear.
// [R08] The watchdog saturates at two; the code clears it to WD_CLR on the second held edge instead.
// [R09] Reaching two on the second held edge resets the link, dropping hold.
// [R10] A forced stop gives exactly one compensating pulse; one second is lost.
// [R11] Writes assert counter_hold exactly as reads do.
// [R12] Written time is clocked in by the link clock, not the 1 Hz tick.
// [R13] The freeze spans one transaction, from START to STOP.
// [R14] The host finishes every read within one second.
// [R15] The host keeps every write shorter than one second.
// [R16] The host reads all time registers in one auto-increment transaction.
// [R17] The host writes all time registers in one transaction.
// [R18] Tick and hold are synchronised into clk before the watchdog uses them.
package rafw_pkg;
	localparam int TIME_W = 32;
	localparam logic [TIME_W-1:0] TIME_RST = 32'h0;
	localparam logic [TIME_W-1:0] TIME_ONE = 32'h1;
	localparam int WD_W = 2;
	localparam logic [WD_W-1:0] WD_CLR = 2'h0;
	localparam logic [WD_W-1:0] WD_ONE = 2'h1;
	localparam logic [WD_W-1:0] WD_MAX = 2'h2;
	typedef enum logic [1:0] {
		RAFW_IDLE,
		RAFW_HELD,
		RAFW_ABORTED
	} rafw_state_t;
endpackage

// ### rafw_xing_if.sv
// Signals crossing between the link-clock logic and the core logic.
// Assumes the core synchronises hold and load_tgl; load_data is read unsynchronised.
`timescale 1ns/1ps
`default_nettype none
interface rafw_xing_if;
	import rafw_pkg::*;
	logic hold;
	logic load_tgl;
	logic [TIME_W-1:0] load_data;
	logic abort;
	modport link (output hold, output load_tgl, output load_data,
		input abort);
	modport core (input hold, input load_tgl, input load_data,
		output abort);
endinterface
`default_nettype wire

// ### rafw_link.sv
// Link-clock side: frames an access between START and STOP and catches
// written time. Assumes start/stop/write strobes are link_clk pulses.
`timescale 1ns/1ps
`default_nettype none
module rafw_link
	import rafw_pkg::*;
(
	// Link clock and reset
	input wire logic link_clk,
	input wire logic nrst,
	// Decoded serial framing
	input wire logic start_det,
	input wire logic stop_det,
	input wire logic wr_stb,
	input wire logic [TIME_W-1:0] wr_data,
	// Crossing to the core
	rafw_xing_if.link xing
);
	logic hold_reg, hold_next;
	logic tgl_reg, tgl_next;
	logic pend_reg, pend_next;
	logic [TIME_W-1:0] data_reg, data_next;
	logic [TIME_W-1:0] stage_reg, stage_next;
	logic abort_meta, abort_s;

	always_ff @(posedge link_clk or negedge nrst) begin
		if (!nrst) begin
			abort_meta <= 1'b0;
			abort_s <= 1'b0;
		end else begin
			abort_meta <= xing.abort;
			abort_s <= abort_meta;
		end
	end

	// A write is staged and only published at STOP, so the core never sees
	// a half-written time; an abort discards it like an interface reset.
	always_comb begin
		hold_next = hold_reg;
		tgl_next = tgl_reg;
		pend_next = pend_reg;
		data_next = data_reg;
		stage_next = stage_reg;
		if (abort_s) begin
			hold_next = 1'b0; // R09
			pend_next = 1'b0;
		end else if (start_det) begin
			hold_next = 1'b1; // R03 R11 R13
			pend_next = 1'b0;
		end else if (stop_det) begin
			hold_next = 1'b0; // R13
			if (pend_reg) begin
				data_next = stage_reg;
				tgl_next = ~tgl_reg;
				pend_next = 1'b0;
			end
		end else if (wr_stb && hold_reg) begin
			stage_next = wr_data; // R12
			pend_next = 1'b1;
		end
	end

	always_ff @(posedge link_clk or negedge nrst) begin
		if (!nrst) begin
			hold_reg <= 1'b0;
			tgl_reg <= 1'b0;
			pend_reg <= 1'b0;
			data_reg <= TIME_RST;
			stage_reg <= TIME_RST;
		end else begin
			hold_reg <= hold_next;
			tgl_reg <= tgl_next;
			pend_reg <= pend_next;
			data_reg <= data_next;
			stage_reg <= stage_next;
		end
	end

	assign xing.hold = hold_reg;
	assign xing.load_tgl = tgl_reg;
	assign xing.load_data = data_reg;

	a_start_holds: assert property (@(posedge link_clk) disable iff (!nrst)
		start_det && !abort_s |=> hold_reg) // R03
		else $error("hold not raised after START");
	a_stop_drops: assert property (@(posedge link_clk) disable iff (!nrst)
		stop_det && !start_det |=> !hold_reg) // R13
		else $error("hold not dropped after STOP");
endmodule
`default_nettype wire

// ### rafw_host.sv
// Host model on the serial side: frames accesses with START, writes, STOP.
// Assumes the bench calls its tasks; link_clk stands still between them.
`timescale 1ns/1ps
`default_nettype none
module rafw_host
	import rafw_pkg::*;
(
	// Link framing
	output logic link_clk,
	output logic start_det,
	output logic stop_det,
	output logic wr_stb,
	output logic [TIME_W-1:0] wr_data
);
	initial begin
		link_clk = 1'h0;
		start_det = 1'h0;
		stop_det = 1'h0;
		wr_stb = 1'h0;
		wr_data = 32'h0;
	end
	// One 64 ns link cycle. Idle data is inverted so stale words never pass.
	// Each strobe is set once per cycle, so back-to-back calls never
	// assign a signal twice in one time step; the link clock stands still
	// afterwards, so a strobe left high is never sampled again.
	task automatic cyc(input logic s, input logic p, input logic w,
		input logic [TIME_W-1:0] d);
		start_det = s;
		stop_det = p;
		wr_stb = w;
		wr_data = w ? d : ~wr_data;
		#32 link_clk = 1'h1;
		#32 link_clk = 1'h0;
	endtask
	// The bench decides how long a frame stays open.
	task automatic start_f;
		cyc(1'h1, 1'h0, 1'h0, 32'h0);
		cyc(1'h0, 1'h0, 1'h0, 32'h0);
	endtask
	task automatic write_w(input logic [TIME_W-1:0] d);
		cyc(1'h0, 1'h0, 1'h1, d);
	endtask
	task automatic stop_f;
		cyc(1'h0, 1'h1, 1'h0, 32'h0);
		cyc(1'h0, 1'h0, 1'h0, 32'h0);
	endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// Bench for the access freeze watchdog: ticks, read, write, forced stop.
// Assumes the host model drives the link and this module drives the ticks.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import rafw_pkg::*;
	logic clk, nrst, tick_1hz, link_clk, start_det, stop_det, wr_stb;
	logic [TIME_W-1:0] wr_data, time_count, exp_t;
	logic counter_hold, forced_stop;
	logic [WD_W-1:0] wd_count;
	int failures, total_checks, cycles, pulses;
	rafw_host u_host (.link_clk(link_clk), .start_det(start_det),
		.stop_det(stop_det), .wr_stb(wr_stb), .wr_data(wr_data));
	rafw_top u_rafw_top (.clk(clk), .nrst(nrst), .tick_1hz(tick_1hz),
		.link_clk(link_clk), .start_det(start_det), .stop_det(stop_det),
		.wr_stb(wr_stb), .wr_data(wr_data), .time_count(time_count),
		.counter_hold(counter_hold), .wd_count(wd_count),
		.forced_stop(forced_stop));
	initial clk = 1'h0;
	always #20 clk = ~clk;
	task automatic results;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles >= 20000) begin
			failures++;
			results;
		end
	end
	task automatic chk(input string n, input logic [31:0] s, e);
		total_checks++;
		if (s !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	// One tick: a long high level so the synchroniser surely sees it.
	task automatic tick;
		@(posedge clk) #1 tick_1hz = 1'h1;
		repeat (8) @(posedge clk);
		#1 tick_1hz = 1'h0;
		repeat (8) @(posedge clk);
	endtask
	task automatic wait_hold(input logic v);
		int n;
		n = 0;
		while (counter_hold !== v && n < 40) begin
			@(posedge clk);
			n++;
		end
		repeat (2) @(posedge clk);
		chk("counter_hold", counter_hold, v);
	endtask
	task automatic t_idle;
		repeat (3) tick;
		chk("time idle", time_count, exp_t + 32'h3);
		exp_t = exp_t + 32'h3;
	endtask
	task automatic t_read;
		u_host.start_f;
		wait_hold(1'h1);
		tick;
		chk("time held", time_count, exp_t);
		chk("wd held", wd_count, WD_ONE);
		u_host.stop_f;
		wait_hold(1'h0);
		exp_t = exp_t + 32'h1;
		chk("time comp", time_count, exp_t);
		chk("wd cleared", wd_count, WD_CLR);
	endtask
	task automatic t_write(input logic [TIME_W-1:0] v, input logic held);
		u_host.start_f;
		wait_hold(1'h1);
		u_host.write_w(~v);
		u_host.write_w(v);
		if (held)
			tick;
		u_host.stop_f;
		wait_hold(1'h0);
		exp_t = v + {31'h0, held};
		chk("time written", time_count, exp_t);
	endtask
	task automatic t_force;
		u_host.start_f;
		wait_hold(1'h1);
		tick;
		pulses = 0;
		@(posedge clk) #1 tick_1hz = 1'h1;
		repeat (30) begin
			@(posedge clk);
			#1 pulses += forced_stop;
		end
		tick_1hz = 1'h0;
		chk("forced pulses", pulses, 1);
		chk("hold dropped", counter_hold, 1'h0);
		chk("wd after abort", wd_count, WD_CLR);
		exp_t = exp_t + 32'h1;
		chk("one second lost", time_count, exp_t);
		u_host.stop_f;
		repeat (8) @(posedge clk);
		tick;
		exp_t = exp_t + 32'h1;
		chk("time resumes", time_count, exp_t);
	endtask
	initial begin
		nrst = 1'h0;
		tick_1hz = 1'h0;
		exp_t = 32'h0;
		#1;
		u_host.cyc(1'h0, 1'h0, 1'h0, 32'h0);
		u_host.cyc(1'h0, 1'h0, 1'h0, 32'h0);
		repeat (4) @(posedge clk);
		#1 nrst = 1'h1;
		chk("time reset", time_count, 32'h0);
		t_idle;
		t_read;
		t_write(32'h0000_1234, 1'h0);
		t_write(32'h0001_5180, 1'h1);
		t_force;
		results;
	end
endmodule
`default_nettype wire
